// [isd_slave_top.sv]
// Purpose: second I2C slave controller with debug port address
// Assumes: APB slave, SCL/SDA open drain, bus at most system_clock/8
// Notes:   debug command handling outside; only the debug interrupt here
//
// Contract
// - debug address match raises debug interrupt
// - debug disabled means plain addressed slave
// - address register: enable bit7, address 6:0
// - receive match sets flag, starts shifting
// - complete received byte sets receive-full flag
// - overrun without stretching answers NACK
// - overrun with stretching holds SCL until cleared
// - transmit match sets flag, loads shifter
// - shifter load sets transmit-empty flag
// - empty transmit with stretching holds SCL low; code skips the hold for the first byte read after a master NACK
// - unrefilled without stretching resends old, NACK
// - master NACK ends data, SDA released
// - filter drops spikes under half cycle
// - filter off passes inputs unfiltered
// - slave and debug coexist; stretching supported
// - direction bit one transmitting, zero receiving
// - soft reset clears machines and address
// - enables route flags onto slave interrupt
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module isd_slave_top (
  input  wire logic        clk,      // system clock
  input  wire logic        rst_n,    // async reset, active low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb enable
  input  wire logic        pwrite,   // apb direction
  input  wire logic [7:0]  paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error
  input  wire logic        sclIn,    // scl pin level
  output logic             sclOut,   // scl drive value, always 0
  output logic             sclOe,    // scl pull low
  input  wire logic        sdaIn,    // sda pin level
  output logic             sdaOut,   // sda drive value, always 0
  output logic             sdaOe,    // sda pull low
  output logic             slaveIrq, // slave controller interrupt
  output logic             debugIrq  // debug interrupt
);
  import isd_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TACK, ST_WAIT} isd_state_e;

  isd_bus_s   pinRaw, bus, busPrev_r;
  isd_state_e state_r;
  logic [7:0] addrReg_r, ctrlReg_r, txBuf_r, rxBuf_r, shift_r;
  logic [6:0] dbgId_r;
  logic       dbgEn_r;
  logic [3:0] bitCnt_r;
  logic       fAddr_r, fStop_r, fRps_r, fTxb_r, fRcb_r, fNack_r, fDbg_r, xmt_r;
  logic       inFrame_r, nackPend_r, ovr_r, stretch_r, sdaDrv_r;
  logic       wrEn, rdEn, sclRise, sclFall, startCond, stopCond, softRst;
  logic       setAddr, setRcb, setTxb, setNack, setDbg, setRps, setStop;
  logic       addrHit, dbgHit;

  assign pinRaw.scl = sclIn;
  assign pinRaw.sda = sdaIn;

  isd_pin_filter u_filter (
    .clk      (clk),
    .rst_n    (rst_n),
    .filterEn (ctrlReg_r[ISD_CTL_FIL]),
    .pinIn    (pinRaw),
    .busOut   (bus)
  );

  // apb decode; access phase completes in one cycle
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && penable && !pwrite;
  assign softRst = ctrlReg_r[ISD_CTL_RST];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busPrev_r <= '1;
    else        busPrev_r <= bus;
  end

  assign sclRise   = bus.scl && !busPrev_r.scl;
  assign sclFall   = !bus.scl && busPrev_r.scl;
  assign startCond = bus.scl && busPrev_r.scl && !bus.sda && busPrev_r.sda;
  assign stopCond  = bus.scl && busPrev_r.scl && bus.sda && !busPrev_r.sda;

  // both addresses compared at once so slave and debug uses coexist
  assign addrHit = addrReg_r[7] && (shift_r[7:1] == addrReg_r[6:0]);
  assign dbgHit  = dbgEn_r && (shift_r[7:1] == dbgId_r);

  // protocol engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      bitCnt_r   <= 4'h0;
      shift_r    <= 8'h00;
      rxBuf_r    <= 8'h00;
      xmt_r      <= 1'b0;
      inFrame_r  <= 1'b0;
      sdaDrv_r   <= 1'b0;
      ovr_r      <= 1'b0;
      stretch_r  <= 1'b0;
    end else if (softRst) begin
      state_r    <= ST_IDLE;
      bitCnt_r   <= 4'h0;
      xmt_r      <= 1'b0;
      inFrame_r  <= 1'b0;
      sdaDrv_r   <= 1'b0;
      ovr_r      <= 1'b0;
      stretch_r  <= 1'b0;
    end else if (startCond) begin
      state_r   <= ST_ADDR;
      bitCnt_r  <= 4'h0;
      inFrame_r <= 1'b1;
      sdaDrv_r  <= 1'b0;
      stretch_r <= 1'b0;
    end else if (stopCond) begin
      state_r   <= ST_IDLE;
      inFrame_r <= 1'b0;
      sdaDrv_r  <= 1'b0;
      stretch_r <= 1'b0;
      xmt_r     <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          sdaDrv_r <= 1'b0;
        end
        ST_ADDR, ST_RX: begin
          if (sclRise) begin
            shift_r  <= {shift_r[6:0], bus.sda};
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (sclFall && bitCnt_r == 4'h8) begin
            bitCnt_r <= 4'h0;
            if (state_r == ST_ADDR) begin
              if (addrHit || dbgHit) begin
                sdaDrv_r <= 1'b1;
                xmt_r    <= shift_r[0];
                state_r  <= ST_ACK;
              end else begin
                state_r <= ST_IDLE;
              end
            end else if (fRcb_r && ctrlReg_r[ISD_CTL_STR]) begin
              stretch_r <= 1'b1;
              ovr_r     <= 1'b1;
              state_r   <= ST_WAIT;
            end else begin
              sdaDrv_r <= !fRcb_r;
              if (!fRcb_r) rxBuf_r <= shift_r;
              state_r  <= ST_ACK;
            end
          end
        end
        ST_WAIT: begin
          // held until software drains the receive buffer
          if (!fRcb_r) begin
            rxBuf_r   <= shift_r;
            sdaDrv_r  <= 1'b1;
            stretch_r <= 1'b0;
            state_r   <= ST_ACK;
          end
        end
        ST_ACK: begin
          // overrun hold ends a cycle after the ack drive: sda settles before scl rises
          ovr_r <= 1'b0;
          if (sclFall) begin
            sdaDrv_r <= 1'b0;
            if (xmt_r) begin
              if (fTxb_r && ctrlReg_r[ISD_CTL_STR] && !nackPend_r) begin
                stretch_r <= 1'b1;
              end else begin
                shift_r  <= txBuf_r;
                sdaDrv_r <= !txBuf_r[7];
                bitCnt_r <= 4'h1;
                state_r  <= ST_TX;
              end
            end else begin
              state_r <= ST_RX;
            end
          end else if (stretch_r && !fTxb_r) begin
            stretch_r <= 1'b0;
            shift_r   <= txBuf_r;
            sdaDrv_r  <= !txBuf_r[7];
            bitCnt_r  <= 4'h1;
            state_r   <= ST_TX;
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (bitCnt_r == 4'h8) begin
              sdaDrv_r <= 1'b0;
              state_r  <= ST_TACK;
            end else begin
              shift_r  <= {shift_r[6:0], 1'b0};
              sdaDrv_r <= !shift_r[6];
              bitCnt_r <= bitCnt_r + 4'h1;
            end
          end
        end
        ST_TACK: begin
          if (sclRise) begin
            if (bus.sda) begin
              state_r <= ST_IDLE;
            end else begin
              state_r <= ST_ACK;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // flag event terms
  assign setAddr = !softRst && state_r == ST_ADDR && sclFall && bitCnt_r == 4'h8
                   && addrHit && !dbgHit;
  assign setDbg  = !softRst && state_r == ST_ADDR && sclFall && bitCnt_r == 4'h8
                   && dbgHit;
  assign setRcb  = !softRst && ((state_r == ST_RX && sclFall && bitCnt_r == 4'h8 && !fRcb_r)
                   || (state_r == ST_WAIT && !fRcb_r));
  assign setTxb  = !softRst && state_r == ST_ACK && xmt_r && !stopCond && !startCond
                   && ((sclFall && !(fTxb_r && ctrlReg_r[ISD_CTL_STR] && !nackPend_r))
                   || (stretch_r && !fTxb_r));
  assign setNack = !softRst && state_r == ST_TACK && sclRise && bus.sda;
  assign setRps  = startCond && inFrame_r && !softRst;
  assign setStop = stopCond && inFrame_r && !softRst;

  // sticky flags: set beats clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fAddr_r <= 1'b0;
      fStop_r <= 1'b0;
      fRps_r  <= 1'b0;
      fTxb_r  <= 1'b0;
      fRcb_r  <= 1'b0;
      fNack_r <= 1'b0;
      fDbg_r  <= 1'b0;
    end else begin
      if (wrEn && paddr == ISD_OFS_STAT) begin
        if (pwdata[ISD_ST_ADDR]) fAddr_r <= 1'b0;
        if (pwdata[ISD_ST_STOP]) fStop_r <= 1'b0;
        if (pwdata[ISD_ST_RPS])  fRps_r  <= 1'b0;
        if (pwdata[ISD_ST_TXB])  fTxb_r  <= 1'b0;
        if (pwdata[ISD_ST_RCB])  fRcb_r  <= 1'b0;
        if (pwdata[ISD_ST_NACK]) fNack_r <= 1'b0;
        if (pwdata[ISD_ST_DBG])  fDbg_r  <= 1'b0;
      end
      if (wrEn && paddr == ISD_OFS_DATA) fTxb_r <= 1'b0;
      if (rdEn && paddr == ISD_OFS_DATA) fRcb_r <= 1'b0;
      if (state_r == ST_TACK && sclRise && !bus.sda) fNack_r <= 1'b0;
      if (setAddr) fAddr_r <= 1'b1;
      if (setStop) fStop_r <= 1'b1;
      if (setRps)  fRps_r  <= 1'b1;
      if (setTxb)  fTxb_r  <= 1'b1;
      if (setRcb)  fRcb_r  <= 1'b1;
      if (setNack) fNack_r <= 1'b1;
      if (setDbg)  fDbg_r  <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) nackPend_r <= 1'b0;
    else if (softRst) nackPend_r <= 1'b0;
    else if (setNack) nackPend_r <= 1'b1;
    else if (state_r == ST_TACK && sclRise) nackPend_r <= 1'b0;
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addrReg_r <= ISD_RST_ADDR;
      ctrlReg_r <= ISD_RST_CTRL;
      txBuf_r   <= 8'h00;
      dbgId_r   <= ISD_RST_DBGID;
      dbgEn_r   <= 1'b0;
    end else begin
      if (wrEn) begin
        case (paddr)
          ISD_OFS_ADDR:  addrReg_r <= pwdata[7:0];
          ISD_OFS_DATA:  txBuf_r   <= pwdata[7:0];
          ISD_OFS_CTRL:  ctrlReg_r <= pwdata[7:0];
          ISD_OFS_DBGID: dbgId_r   <= pwdata[6:0];
          ISD_OFS_DBGEN: dbgEn_r   <= pwdata[0];
          default:       ;
        endcase
      end
      if (softRst) addrReg_r <= ISD_RST_ADDR;
    end
  end

  // apb answer, pins and interrupts all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      sclOut   <= 1'b0;
      sclOe    <= 1'b0;
      sdaOut   <= 1'b0;
      sdaOe    <= 1'b0;
      slaveIrq <= 1'b0;
      debugIrq <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          ISD_OFS_ADDR:  prdata <= {24'h000000, addrReg_r};
          ISD_OFS_DATA:  prdata <= {24'h000000, rxBuf_r};
          ISD_OFS_CTRL:  prdata <= {24'h000000, 7'h00, xmt_r};
          ISD_OFS_STAT:  prdata <= {24'h000000, xmt_r, fDbg_r, fNack_r, fRcb_r,
                                    fTxb_r, fRps_r, fStop_r, fAddr_r};
          ISD_OFS_DBGID: prdata <= {25'h0000000, dbgId_r};
          ISD_OFS_DBGEN: prdata <= {31'h00000000, dbgEn_r};
          default:       prdata <= 32'h0000_0000;
        endcase
        pslverr <= paddr > ISD_OFS_DBGEN || paddr[1:0] != 2'b00;
      end
      sclOut   <= 1'b0;
      sclOe    <= stretch_r || ovr_r;
      sdaOut   <= 1'b0;
      sdaOe    <= sdaDrv_r;
      slaveIrq <= (fAddr_r && ctrlReg_r[ISD_CTL_EADDR]) || (fStop_r && ctrlReg_r[ISD_CTL_ESTOP])
               || (fRps_r && ctrlReg_r[ISD_CTL_ERPS]) || (fTxb_r && ctrlReg_r[ISD_CTL_ETXB])
               || (fRcb_r && ctrlReg_r[ISD_CTL_ERCB]);
      debugIrq <= fDbg_r;
    end
  end
endmodule
`default_nettype wire

// [isd_pkg.sv]
// Purpose: shared constants and types for the second I2C slave controller
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   offsets are byte addresses
package isd_pkg;

  localparam logic [7:0] ISD_OFS_ADDR  = 8'h00;
  localparam logic [7:0] ISD_OFS_DATA  = 8'h04;
  localparam logic [7:0] ISD_OFS_CTRL  = 8'h08;
  localparam logic [7:0] ISD_OFS_STAT  = 8'h0C;
  localparam logic [7:0] ISD_OFS_DBGID = 8'h10;
  localparam logic [7:0] ISD_OFS_DBGEN = 8'h14;

  // control register fields
  localparam int ISD_CTL_RST   = 7;
  localparam int ISD_CTL_EADDR = 6;
  localparam int ISD_CTL_ESTOP = 5;
  localparam int ISD_CTL_ERPS  = 4;
  localparam int ISD_CTL_ETXB  = 3;
  localparam int ISD_CTL_ERCB  = 2;
  localparam int ISD_CTL_STR   = 1;
  localparam int ISD_CTL_FIL   = 0;

  // status register fields, write one to clear, except ISD_ST_XMT which is read only
  localparam int ISD_ST_ADDR  = 0;
  localparam int ISD_ST_STOP  = 1;
  localparam int ISD_ST_RPS   = 2;
  localparam int ISD_ST_TXB   = 3;
  localparam int ISD_ST_RCB   = 4;
  localparam int ISD_ST_NACK  = 5;
  localparam int ISD_ST_DBG   = 6;
  localparam int ISD_ST_XMT   = 7;

  localparam logic [7:0] ISD_RST_ADDR  = 8'h00;
  localparam logic [7:0] ISD_RST_CTRL  = 8'h00;
  localparam logic [6:0] ISD_RST_DBGID = 7'h00;

  localparam int ISD_SYNC_STAGES = 3;

  typedef struct packed {
    logic scl;
    logic sda;
  } isd_bus_s;

  typedef struct packed {
    logic addrMatch;
    logic stop;
    logic rptStart;
  } isd_evt_s;

endpackage

// [isd_pin_filter.sv]
// Purpose: three-flop sampling and optional spike filtering of SCL and SDA
// Assumes: pins are asynchronous to clk
// Notes:   with filterEn set a change counts once stages two and three agree, else at stage two
`timescale 1ns/1ps
`default_nettype none
module isd_pin_filter (
  input  wire logic            clk,        // system clock
  input  wire logic            rst_n,      // async reset, active low
  input  wire logic            filterEn,   // spike filter enable
  input  wire isd_pkg::isd_bus_s pinIn,    // raw pin levels
  output var  isd_pkg::isd_bus_s busOut    // cleaned levels
);
  import isd_pkg::*;

  isd_bus_s stg1_r, stg2_r, stg3_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stg1_r <= '1;
      stg2_r <= '1;
      stg3_r <= '1;
    end else begin
      stg1_r <= pinIn;
      stg2_r <= stg1_r;
      stg3_r <= stg2_r;
    end
  end

  // filtered: accept only when two samples agree, so a sub-cycle spike is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busOut <= '1;
    end else if (!filterEn) begin
      busOut <= stg2_r;
    end else begin
      if (stg2_r.scl == stg3_r.scl) busOut.scl <= stg2_r.scl;
      if (stg2_r.sda == stg3_r.sda) busOut.sda <= stg2_r.sda;
    end
  end
endmodule
`default_nettype wire

// [isd_slave_checker.sv]
// Purpose: port-level assertions for the second I2C slave controller
// Assumes: zero-wait APB, open-drain pins resolved outside
// Notes:   bound to every isd_slave_top
`timescale 1ns/1ps
`default_nettype none
module isd_slave_checker (
  input  wire logic        clk,      // system clock
  input  wire logic        rst_n,    // async reset
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb enable
  input  wire logic        pwrite,   // apb direction
  input  wire logic [7:0]  paddr,    // apb address
  input  wire logic [31:0] pwdata,   // apb write data
  input  wire logic [31:0] prdata,   // apb read data
  input  wire logic        pready,   // apb ready
  input  wire logic        pslverr,  // apb error
  input  wire logic        sclIn,    // scl level
  input  wire logic        sclOut,   // scl drive value
  input  wire logic        sclOe,    // scl pull low
  input  wire logic        sdaIn,    // sda level
  input  wire logic        sdaOut,   // sda drive value
  input  wire logic        sdaOe,    // sda pull low
  input  wire logic        slaveIrq, // slave interrupt
  input  wire logic        debugIrq  // debug interrupt
);
  logic wAcc;
  assign wAcc = psel && penable && pwrite && pready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready && paddr > 8'h14 |-> pslverr)
    else $error("no error for unmapped address");
  a_err_mapped: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_open_drain: assert property (!sclOut && !sdaOut)
    else $error("pin drive value not low");
  a_stretch_low: assert property ($rose(sclOe) |-> !$past(sclIn))
    else $error("scl pulled while high");
  a_irq_masked: assert property (wAcc && paddr == 8'h08 && pwdata[6:2] == 5'h0
    |-> ##[1:3] !slaveIrq)
    else $error("interrupt with all enables off");
  a_soft_idle: assert property (wAcc && paddr == 8'h08 && pwdata[7] |-> ##[1:3] !sclOe && !sdaOe)
    else $error("pins driven in soft reset");
  a_dbg_clear: assert property (wAcc && paddr == 8'h0C && pwdata[6] |-> ##[1:3] !debugIrq)
    else $error("debug interrupt not cleared");
  c_stretch: cover property ($rose(sclOe));
  c_debug: cover property ($rose(debugIrq));
  c_error: cover property (pready && pslverr);
endmodule
bind isd_slave_top isd_slave_checker u_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .slaveIrq(slaveIrq), .debugIrq(debugIrq)
);
`default_nettype wire

// [isd_i2c_master.sv]
// Purpose: behavioural I2C bus master for the slave bench
// Assumes: pull-ups on both lines, 800 ns bit period
// Notes:   waits on a stretched scl, bounded
`timescale 1ns/1ps
`default_nettype none
module isd_i2c_master (
  input  wire logic sclLine, // resolved scl
  input  wire logic sdaLine, // resolved sda
  output var  logic sclDrv,  // low pulls scl
  output var  logic sdaDrv   // low pulls sda
);
  int stalls = 0;
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  // low 600 ns, high 200 ns: 8 system clocks a bit
  task automatic xfer(input logic b, output logic s);
    int n;
    #100 sdaDrv = b;
    #500 sclDrv = 1'b1;
    n = 0;
    while (sclLine !== 1'b1 && n < 2000) begin
      #100;
      n++;
    end
    if (n >= 2000) stalls++;
    #100 s = sdaLine;
    #100 sclDrv = 1'b0;
  endtask
  task automatic start();
    sdaDrv = 1'b1;
    sclDrv = 1'b1;
    #400 sdaDrv = 1'b0;
    #400 sclDrv = 1'b0;
  endtask
  task automatic stop();
    #100 sdaDrv = 1'b0;
    #500 sclDrv = 1'b1;
    #400 sdaDrv = 1'b1;
    #400;
  endtask
  task automatic wrbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xfer(d[i], s);
    xfer(1'b1, ack);
  endtask
  task automatic rdbyte(input logic nak, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(nak, s);
  endtask
endmodule
`default_nettype wire

// [isd_slave_tb_top.sv]
// Purpose: self-checking bench for the second I2C slave controller
// Assumes: slave address 0x2A, debug address 0x3B
// Notes:   filter spikes are not provoked
`timescale 1ns/1ps
`default_nettype none
module isd_slave_tb_top;
  import isd_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, sclOe, sdaOe, slaveIrq, debugIrq, sclDrv, sdaDrv;
  logic        err, ack;
  logic [7:0]  d;
  wire         sclLine = sclDrv & ~sclOe;
  wire         sdaLine = sdaDrv & ~sdaOe;
  int          fails = 0;
  int          comparisons = 0;
  always #50 clk = ~clk;
  isd_slave_top dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclIn(sclLine), .sclOut(), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe),
    .slaveIrq(slaveIrq), .debugIrq(debugIrq)
  );
  isd_i2c_master m (.sclLine(sclLine), .sdaLine(sdaLine), .sclDrv(sclDrv), .sdaDrv(sdaDrv));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmpb(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(q & mk, e);
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", fails + m.stalls, comparisons);
    if (fails + m.stalls == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdc(ISD_OFS_ADDR, 32'hFF, {24'h0, ISD_RST_ADDR});
    rdc(8'h18, 32'hFFFFFFFF, 32'h0);
    cmpb(err, 1'b1);
    wr(ISD_OFS_ADDR, 32'hAA);
    wr(ISD_OFS_CTRL, 32'h7C);
    m.start();
    m.wrbyte(8'h54, ack);
    cmpb(ack, 1'b0);
    rdc(ISD_OFS_STAT, 32'h81, 32'h01);
    m.wrbyte(8'hA5, ack);
    rdc(ISD_OFS_STAT, 32'h10, 32'h10);
    cmpb(slaveIrq, 1'b1);
    m.wrbyte(8'h3C, ack);
    cmpb(ack, 1'b1);
    rdc(ISD_OFS_DATA, 32'hFF, 32'hA5);
    rdc(ISD_OFS_STAT, 32'h10, 32'h0);
    m.stop();
    rdc(ISD_OFS_STAT, 32'h02, 32'h02);
    wr(ISD_OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    cmpb(slaveIrq, 1'b0);
    wr(ISD_OFS_STAT, 32'h7F);
    m.start();
    m.wrbyte(8'hAA, ack);
    cmpb(ack, 1'b1);
    m.stop();
    wr(ISD_OFS_DATA, 32'h96);
    m.start();
    m.wrbyte(8'h55, ack);
    cmpb(ack, 1'b0);
    repeat (8) @(posedge clk);
    rdc(ISD_OFS_STAT, 32'h89, 32'h89);
    m.rdbyte(1'b0, d);
    cmp({24'h0, d}, 32'h96);
    m.rdbyte(1'b1, d);
    cmp({24'h0, d}, 32'h96);
    #800;
    cmpb(sdaOe, 1'b0);
    rdc(ISD_OFS_STAT, 32'h20, 32'h20);
    m.stop();
    wr(ISD_OFS_STAT, 32'hFF);
    wr(ISD_OFS_CTRL, 32'h02);
    m.start();
    m.wrbyte(8'h54, ack);
    m.wrbyte(8'h11, ack);
    fork
      m.wrbyte(8'h22, ack);
      begin
        repeat (120) @(posedge clk);
        cmpb(sclOe, 1'b1);
        rdc(ISD_OFS_DATA, 32'hFF, 32'h11);
      end
    join
    cmpb(ack, 1'b0);
    rdc(ISD_OFS_DATA, 32'hFF, 32'h22);
    m.stop();
    wr(ISD_OFS_DATA, 32'h5A);
    m.start();
    m.wrbyte(8'h55, ack);
    m.rdbyte(1'b0, d);
    cmp({24'h0, d}, 32'h5A);
    fork
      m.rdbyte(1'b1, d);
      begin
        repeat (40) @(posedge clk);
        cmpb(sclOe, 1'b1);
        wr(ISD_OFS_DATA, 32'hC3);
      end
    join
    cmp({24'h0, d}, 32'hC3);
    m.stop();
    wr(ISD_OFS_STAT, 32'hFF);
    wr(ISD_OFS_DBGID, 32'h3B);
    wr(ISD_OFS_DBGEN, 32'h1);
    wr(ISD_OFS_CTRL, 32'h01);
    m.start();
    m.wrbyte(8'h76, ack);
    cmpb(ack, 1'b0);
    m.stop();
    cmpb(debugIrq, 1'b1);
    m.start();
    m.wrbyte(8'h54, ack);
    cmpb(ack, 1'b0);
    m.stop();
    wr(ISD_OFS_STAT, 32'h40);
    repeat (3) @(posedge clk);
    cmpb(debugIrq, 1'b0);
    wr(ISD_OFS_CTRL, 32'h80);
    rdc(ISD_OFS_ADDR, 32'hFF, 32'h0);
    wr(ISD_OFS_CTRL, 32'h0);
    m.start();
    m.wrbyte(8'h54, ack);
    cmpb(ack, 1'b1);
    m.stop();
    results();
  end
endmodule
`default_nettype wire
